//--- design/pba_params.svh
`ifndef PBA_PARAMS_SVH
`define PBA_PARAMS_SVH
`define PBA_NMASTERS    4
`define PBA_SLOT_IDX    0
`define PBA_BRIDGE_IDX  3
`define PBA_AD_W        32
`define PBA_ADDR_STEP   32'h0000_0004
`define PBA_BEAT_W      8
`define PBA_CFG_ADDR_CYCLE 4'hB
`define PBA_CFG_TAG_W   4
`define PBA_HOLD_W      2
`define PBA_GNT_HOLD    2'h2
`endif

//--- design/pba_pkg.sv
package pba_pkg;
  `include "pba_params.svh"
  typedef logic [`PBA_NMASTERS-1:0] pba_vec_t;
  typedef logic [`PBA_AD_W-1:0]     pba_word_t;
  typedef enum logic [1:0] {
    PBA_M_IDLE = 2'b00,
    PBA_M_WAIT = 2'b01,
    PBA_M_ADDR = 2'b10,
    PBA_M_DATA = 2'b11
  } pba_mstate_t;
endpackage : pba_pkg

//--- design/pba_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pba_bus_if;
  import pba_pkg::*;
  pba_vec_t  req;
  pba_vec_t  gnt;
  logic      frame;
  logic      frame_oe_n;
  pba_word_t ad;
  logic      ad_oe_n;
  logic      pme_n;
  logic      in_use;
  modport arbiter (input req, frame, frame_oe_n, pme_n, output gnt);
  modport master  (input gnt, in_use, output req, frame, frame_oe_n, ad, ad_oe_n, pme_n);
endinterface : pba_bus_if
`default_nettype wire

//--- design/pba_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
`include "pba_params.svh"
module pba_arbiter
  import pba_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  pba_bus_if.arbiter  bus,
  output logic        pme_event,
  output var pba_vec_t owner
);
  typedef struct packed {
    pba_vec_t gnt;
    logic     busy;
    logic     pme_d;
    logic     pme_ev;
    logic [`PBA_HOLD_W-1:0] hold;
  } pba_arb_st_t;

  pba_arb_st_t st_reg;
  pba_arb_st_t st_next;

  // rotate priority starting just past the current holder
  function automatic pba_vec_t pba_pick(input pba_vec_t r, input pba_vec_t last);
    pba_vec_t res;
    int       base;
    int       k;
    res  = '0;
    base = 0;
    for (int i = 0; i < `PBA_NMASTERS; i++) begin
      if (last[i]) base = i;
    end
    for (int j = `PBA_NMASTERS; j >= 1; j--) begin
      k = (base + j) % `PBA_NMASTERS;
      if (r[k]) res = pba_vec_t'(1) << k;
    end
    return res;
  endfunction : pba_pick

  always_comb begin
    pba_vec_t others;
    others         = bus.req & ~st_reg.gnt;
    st_next        = st_reg;
    st_next.pme_d  = ~bus.pme_n;
    st_next.pme_ev = ~bus.pme_n & ~st_reg.pme_d;
    st_next.busy   = bus.frame;
    if (st_reg.hold != '0) st_next.hold = st_reg.hold - `PBA_HOLD_W'(1);
    // switch only between transactions so a running burst keeps the bus;
    // hold covers the grantee's climb from grant to frame
    if (!bus.frame && !st_reg.busy && st_reg.hold == '0) begin
      if (others != '0) begin
        st_next.gnt = pba_pick(bus.req, st_reg.gnt);
      end else if (st_reg.gnt[`PBA_BRIDGE_IDX] && !bus.req[`PBA_BRIDGE_IDX]) begin
        st_next.gnt = '0;
      end else if (st_reg.gnt == '0) begin
        st_next.gnt = pba_pick(bus.req, st_reg.gnt);
      end
    end
    if (st_next.gnt != st_reg.gnt && st_next.gnt != '0) st_next.hold = `PBA_GNT_HOLD;
  end

  always_ff @(posedge clk) begin
    if (rst) st_reg <= '0;
    else     st_reg <= st_next;
  end

  assign bus.gnt   = st_reg.gnt;
  assign pme_event = st_reg.pme_ev;
  assign owner     = st_reg.gnt;
endmodule : pba_arbiter
`default_nettype wire

//--- design/pba_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "pba_params.svh"
module pba_master
  import pba_pkg::*;
#(
  parameter int IDX = `PBA_SLOT_IDX
)(
  input  wire logic            clk,
  input  wire logic            rst,
  pba_bus_if.master            bus,
  input  wire logic            start,
  input  wire pba_word_t       addr,
  input  wire logic [`PBA_BEAT_W-1:0] beats,
  input  wire logic            cfg,
  input  wire logic            pme_req,
  output logic                 busy,
  output var pba_word_t        cur_addr
);
  typedef struct packed {
    pba_mstate_t         state;
    logic                req;
    logic                frame;
    pba_word_t           ad;
    pba_word_t           addr;
    logic [`PBA_BEAT_W-1:0] left;
    logic                pme;
  } pba_mst_st_t;

  pba_mst_st_t st_reg;
  pba_mst_st_t st_next;
  logic        mine;

  assign mine = bus.gnt[IDX];

  always_comb begin
    st_next     = st_reg;
    st_next.pme = pme_req;
    case (st_reg.state)
      PBA_M_IDLE: begin
        if (start) begin
          st_next.addr = addr;
          st_next.left = (beats == '0) ? `PBA_BEAT_W'(1) : beats;
          // owner still waits for the previous burst to clear the bus
          if (mine && !bus.in_use) st_next.state = PBA_M_ADDR;
          else begin
            st_next.req   = 1'b1;
            st_next.state = PBA_M_WAIT;
          end
        end
      end
      PBA_M_WAIT: begin
        if (mine && !bus.in_use) begin
          st_next.req   = 1'b0;
          st_next.state = PBA_M_ADDR;
        end
      end
      PBA_M_ADDR: begin
        // grant moved at the launch edge: back off and ask again
        if (!mine) begin
          st_next.req   = 1'b1;
          st_next.state = PBA_M_WAIT;
        end else begin
          st_next.frame = 1'b1;
          // config cycles carry a type-one style address tag in the low bits
          st_next.ad    = cfg ? {st_reg.addr[`PBA_AD_W-1:`PBA_CFG_TAG_W], `PBA_CFG_ADDR_CYCLE}
                              : st_reg.addr;
          st_next.state = PBA_M_DATA;
        end
      end
      PBA_M_DATA: begin
        // frame stays up through the last beat
        if (st_reg.left == '0) begin
          st_next.frame = 1'b0;
          st_next.state = PBA_M_IDLE;
        end else begin
          st_next.ad   = st_reg.addr;
          st_next.addr = st_reg.addr + `PBA_ADDR_STEP;
          st_next.left = st_reg.left - `PBA_BEAT_W'(1);
        end
      end
      default: st_next.state = PBA_M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) st_reg <= '0;
    else     st_reg <= st_next;
  end

  always_comb begin
    bus.req      = '0;
    bus.req[IDX] = st_reg.req;
  end
  assign bus.frame      = st_reg.frame;
  assign bus.frame_oe_n = ~st_reg.frame;
  assign bus.ad         = st_reg.ad;
  assign bus.ad_oe_n    = ~st_reg.frame;
  assign bus.pme_n      = ~st_reg.pme;
  assign busy           = (st_reg.state != PBA_M_IDLE);
  assign cur_addr       = st_reg.addr;
endmodule : pba_master
`default_nettype wire

//--- tb/pba_props.sv
`timescale 1ns/10ps
`default_nettype none
module pba_props
  import pba_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst,
  input wire pba_vec_t req,
  input wire pba_vec_t gnt,
  input wire pba_vec_t frames,
  input wire logic     frame
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_one_grant: assert property ($onehot0(gnt)) else $error("two grants");
  a_grant_req: assert property (
    $changed(gnt) && gnt != 0 |-> (gnt & $past(req)) != 0) else $error("unasked grant");
  a_one_frame: assert property ($onehot0(frames)) else $error("two frames");
  a_grant_time: assert property (
    req != 0 && gnt == 0 |-> ##[1:4] gnt != 0) else $error("grant late");
  a_frame_hold: assert property (frame |=> $stable(gnt)) else $error("grant moved");
  a_park_owner: assert property (
    gnt[2:0] != 0 && req == 0 |=> $stable(gnt)) else $error("park lost");
  a_frame_owner: assert property (
    $rose(frame) |-> $past(gnt) != 0) else $error("frame unowned");
  a_slot_fair: assert property (
    req[0] |-> ##[0:100] gnt[0]) else $error("slot starved");
  a_two_cycles: assert property ($rose(frame) |=> frame) else $error("no data cycle");
  c_slot: cover property (gnt[0] && frame);
  c_bridge: cover property (gnt[3] && frame);
  c_handover: cover property ($changed(gnt) && $past(gnt) != 0 && gnt != 0);
endmodule : pba_props
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pba_params.svh"
module tb_top;
  import pba_pkg::*;
  logic            clk = 0, rst = 1, pev, r1 = 0, r2 = 0, r3 = 0;
  logic [3:0]      st = 0, cf = 0, pr = 0, bz;
  pba_word_t [3:0] ad_in = '0;
  logic [3:0][7:0] bt = '0;
  int              mismatches = 0, n_tests = 0, cyc = 0;
  pba_word_t       qa [4][$];
  int              qn [4][$];
  pba_bus_if ab ();
  pba_bus_if mb [4] ();
  pba_arbiter pba_arbiter_i (.clk(clk), .rst(rst), .bus(ab), .pme_event(pev), .owner());
  pba_props pba_props_i (.clk(clk), .rst(rst), .req(ab.req), .gnt(ab.gnt),
    .frames({mb[3].frame, mb[2].frame, mb[1].frame, mb[0].frame}), .frame(ab.frame));
  assign ab.in_use = ab.frame;
  assign ab.req = {mb[3].req[3], mb[2].req[2], mb[1].req[1], mb[0].req[0]};
  assign ab.frame = mb[0].frame | mb[1].frame | mb[2].frame | mb[3].frame;
  assign ab.frame_oe_n = mb[0].frame_oe_n & mb[1].frame_oe_n & mb[2].frame_oe_n & mb[3].frame_oe_n;
  assign ab.pme_n = mb[0].pme_n & mb[1].pme_n & mb[2].pme_n & mb[3].pme_n;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  for (genvar k = 0; k < 4; k++) begin : g
    int        cnt  = 0;
    pba_word_t base = '0;
    pba_master #(.IDX(k)) pba_master_i (.clk(clk), .rst(rst), .bus(mb[k]), .start(st[k]),
      .addr(ad_in[k]), .beats(bt[k]), .cfg(cf[k]), .pme_req(pr[k]), .busy(bz[k]), .cur_addr());
    assign mb[k].gnt    = ab.gnt;
    assign mb[k].in_use = ab.frame;
    // negedge: registered bus values are settled here
    always @(negedge clk) if (!rst) begin
      if (mb[k].frame) begin
        if (cnt == 0) begin
          base = qa[k].pop_front();
          chk("ad", mb[k].ad, base);
          base = base & 32'hFFFF_FFF0;
        end else begin
          chk("beat", mb[k].ad, base + 32'(cnt - 1) * `PBA_ADDR_STEP);
        end
        cnt++;
      end else if (cnt != 0) begin
        chk("cycles", cnt, qn[k].pop_front());
        cnt = 0;
      end
    end
  end
  initial forever #50 clk = ~clk;
  // power event model: pulse two edges after the request rises
  always @(posedge clk) begin
    r1 <= |pr;
    r2 <= r1;
    r3 <= r2;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  always @(negedge clk) if (!rst) chk("pme_event", pev, r2 & !r3);
  initial begin
    void'($urandom(10));
    repeat (16) @(negedge clk);
    rst = 0;
    repeat (3000) begin
      @(negedge clk);
      for (int k = 0; k < 4; k++) begin
        st[k] = !bz[k] && !st[k] && ($urandom % 3 == 0);
        if ($urandom % 40 == 0) pr[k] = !pr[k];
        if (st[k]) begin
          ad_in[k] = $urandom & 32'hFFFF_FFF0;
          bt[k] = 8'($urandom % 8);
          cf[k] = $urandom % 2;
          qa[k].push_back(ad_in[k] | (cf[k] ? 32'h0000_000B : 32'h0000_0000));
          qn[k].push_back(1 + (bt[k] == 0 ? 1 : bt[k]));
        end
      end
    end
    @(negedge clk);
    st = 0;
    repeat (200) @(negedge clk);
    for (int k = 0; k < 4; k++) chk("pending", qn[k].size(), 0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
